// ==== logic/uart_rx_brk_pkg.sv ====
// Constants and carrier types for the receiver and break generator
package uart_rx_brk_pkg;
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam logic [3:0] OVS_LAST = 4'hf;
  localparam logic [3:0] VOTE_A = 4'h7;
  localparam logic [3:0] VOTE_B = 4'h8;
  localparam logic [3:0] VOTE_C = 4'h9;
  localparam logic [3:0] BREAK_ZEROS = 4'hd;
  localparam logic [3:0] BITS_8 = 4'h8;
  localparam logic [3:0] BITS_9 = 4'h9;
  localparam logic [7:0] DIV_RESET = 8'h00;
  localparam logic [8:0] WORD_RESET = 9'h000;
  localparam logic [4:0] COUNT_RESET = 5'h00;

  typedef enum logic [2:0] {
    RX_OFF = 3'b000,
    RX_HUNT = 3'b001,
    RX_START = 3'b010,
    RX_DATA = 3'b011,
    RX_PAR = 3'b100,
    RX_STOP = 3'b101,
    RX_WAIT_HIGH = 3'b110
  } rx_state_t;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_START = 2'b01,
    TX_ZERO = 2'b10,
    TX_STOP = 2'b11
  } tx_state_t;

  // Line format and control bits from software
  typedef struct packed {
    logic port_enable_bit;
    logic receive_enable_bit;
    logic word_length_select;
    logic parity_enable_bit;
    logic parity_type_bit;
    logic two_stop_bits;
    logic receive_interrupt_enable;
    logic break_request_bit;
  } ctrl_t;

  // Flags visible to software
  typedef struct packed {
    logic data_available_flag;
    logic overrun_flag;
    logic noise_flag;
    logic framing_flag;
    logic parity_error_flag;
    logic receive_idle_flag;
  } status_t;

  // One buffered word with its own error marks
  typedef struct packed {
    logic [8:0] data;
    logic framing;
    logic parity;
    logic noise;
  } entry_t;

  localparam entry_t ENTRY_RESET = '0;
endpackage : uart_rx_brk_pkg

// ==== logic/uart_receiver_and_break.sv ====
// Receive path with 16x oversampling, two-word buffer, and break transmit
//
// Behaviour
// - Break starts on next frame after request held beyond divisor+1 clocks.
// - Break frame is start, 13*N zeros, then stop bits.
// - Break frames never raise a transmit interrupt.
// - Breaks repeat while requested; last finishes then one or two stops.
// - Eight or nine data bits; ninth bit goes to its own field.
// - Recovery runs at 16x baud; shifter advances once per bit.
// - Each bit level is a majority of three samples.
// - Data shifts in least significant bit first.
// - Buffer holds two words; third completing unread means overrun.
// - Overrun sets flag, keeps buffer, drops shift word, may interrupt.
// - Receiver hunts for a start bit once port enable and receive enable are both set.
// - Word into buffer sets data available; interrupt if enabled, also overrun.
// - Data, overrun, noise flags clear on status access then data read.
// - Break is framing error; zeros loaded, flags and idle set.
// - After bad frame, wait for high line before hunting again.
// - Idle is low from start detect to stop sample, else high.
// - Noise flag rises with data available; word still transferred.
// - Framing error when stop bit sampled low.
// - Parity error on mismatch, only when parity is enabled.
// - After the stop sample the word enters the buffer if free.
// - Port disable empties buffer, clears flags and enable, sets idle.
// - Receiver checks only one stop bit.
`timescale 1ns/1ps
module uart_receiver_and_break (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire uart_rx_brk_pkg::ctrl_t ctrl,
  input wire logic [7:0] baud_divisor_value,
  input wire logic rx_pin,
  input wire logic status_access,
  input wire logic data_read,
  output uart_rx_brk_pkg::status_t status,
  output logic [7:0] serial_data_buffer,
  output logic receive_ninth_bit,
  output logic receive_enable_out,
  output logic rx_irq,
  output logic tx_pin,
  output logic tx_irq,
  output logic break_active
);
  import uart_rx_brk_pkg::*;

  typedef struct packed {
    logic [7:0] div_cnt;
    logic [3:0] ovs_cnt;
    logic [2:0] votes;
    rx_state_t rx_state;
    logic [3:0] bit_cnt;
    logic [8:0] receive_shift_register;
    logic frame_noise;
    logic par_bit;
    entry_t [1:0] fifo;
    logic [1:0] fill;
    status_t st;
    logic status_seen;
    logic rx_en;
    logic rx_irq;
    logic [8:0] req_cnt;
    logic brk_armed;
    tx_state_t tx_state;
    logic [3:0] tx_ovs;
    logic [4:0] tx_bits;
    logic tx_pin;
    logic second_stop;
  } state_t;

  state_t s_reg;
  state_t s_next;

  logic tick;
  logic voted;
  logic noisy;
  logic [3:0] data_bits;
  logic word_done;
  logic frame_bad;
  logic par_bad;
  logic pop;
  logic [8:0] word;
  logic [8:0] par_calc;

  always_comb begin
    s_next = s_reg;
    tick = (s_reg.div_cnt == baud_divisor_value);
    voted = (s_reg.votes[0] & s_reg.votes[1]) | (s_reg.votes[0] & s_reg.votes[2])
      | (s_reg.votes[1] & s_reg.votes[2]);
    noisy = ~(&s_reg.votes) & (|s_reg.votes);
    data_bits = ctrl.word_length_select ? BITS_9 : BITS_8;
    word_done = 1'b0;
    frame_bad = 1'b0;
    par_bad = 1'b0;
    word = s_reg.receive_shift_register;
    if (!ctrl.word_length_select) begin
      word = {1'b0, s_reg.receive_shift_register[8:1]};
    end
    par_calc = word;
    pop = 1'b0;
    s_next.rx_irq = 1'b0;

    s_next.div_cnt = tick ? DIV_RESET : s_reg.div_cnt + 8'h01;

    // Oversampling and bit recovery
    if (tick) begin
      s_next.ovs_cnt = s_reg.ovs_cnt + 4'h1;
      if (s_reg.ovs_cnt == VOTE_A || s_reg.ovs_cnt == VOTE_B ||
          s_reg.ovs_cnt == VOTE_C) begin
        s_next.votes = {s_reg.votes[1:0], rx_pin};
      end
      if (s_reg.ovs_cnt == OVS_LAST) begin
        case (s_reg.rx_state)
          RX_START: begin
            if (voted) begin
              s_next.rx_state = RX_HUNT;
              s_next.st.receive_idle_flag = 1'b1;
            end else begin
              s_next.rx_state = RX_DATA;
              s_next.frame_noise = noisy;
            end
          end
          RX_DATA: begin
            s_next.receive_shift_register = {voted, s_reg.receive_shift_register[8:1]};
            s_next.frame_noise = s_reg.frame_noise | noisy;
            s_next.bit_cnt = s_reg.bit_cnt + 4'h1;
            if (s_reg.bit_cnt + 4'h1 == data_bits) begin
              s_next.rx_state = ctrl.parity_enable_bit ? RX_PAR : RX_STOP;
            end
          end
          RX_PAR: begin
            s_next.par_bit = voted;
            s_next.frame_noise = s_reg.frame_noise | noisy;
            s_next.rx_state = RX_STOP;
          end
          RX_STOP: begin
            word_done = 1'b1;
            frame_bad = ~voted;
            par_bad = ctrl.parity_enable_bit &
              ((^par_calc ^ s_reg.par_bit) != ctrl.parity_type_bit);
            s_next.st.receive_idle_flag = 1'b1;
            s_next.rx_state = voted ? RX_HUNT : RX_WAIT_HIGH;
          end
          default: begin
          end
        endcase
      end
    end

    // Start search runs on every tick, not only at bit boundaries
    if (tick && s_reg.rx_state == RX_HUNT && !rx_pin) begin
      s_next.rx_state = RX_START;
      s_next.ovs_cnt = 4'h1;
      s_next.bit_cnt = 4'h0;
      s_next.st.receive_idle_flag = 1'b0;
    end
    if (tick && s_reg.rx_state == RX_WAIT_HIGH && rx_pin) begin
      s_next.rx_state = RX_HUNT;
      s_next.st.receive_idle_flag = 1'b1;
    end
    if (s_reg.rx_state == RX_OFF && ctrl.receive_enable_bit) begin
      s_next.rx_state = RX_HUNT;
      s_next.rx_en = 1'b1;
    end

    // Read side of the buffer
    if (status_access) begin
      s_next.status_seen = 1'b1;
    end
    if (data_read && s_reg.fill != 2'd0) begin
      pop = 1'b1;
      s_next.fifo[0] = s_reg.fifo[1];
      s_next.fill = s_reg.fill - 2'd1;
      if (s_reg.status_seen) begin
        s_next.st.overrun_flag = 1'b0;
        s_next.status_seen = 1'b0;
      end
      s_next.st.data_available_flag = (s_reg.fill != 2'd1) |
        ~s_reg.status_seen;
      s_next.st.noise_flag = s_reg.status_seen ? s_reg.fifo[1].noise
        & (s_reg.fill == 2'd2) : s_reg.st.noise_flag;
      s_next.st.framing_flag = s_reg.fifo[1].framing & (s_reg.fill == 2'd2);
      s_next.st.parity_error_flag = s_reg.fifo[1].parity & (s_reg.fill == 2'd2);
    end

    // Write side; set wins over a same-cycle clear
    if (word_done) begin
      if (s_reg.fill == 2'd2 && !pop) begin
        s_next.st.overrun_flag = 1'b1;
        s_next.rx_irq = ctrl.receive_interrupt_enable;
      end else begin
        s_next.fill = s_next.fill + 2'd1;
        s_next.fifo[s_next.fill - 2'd1] = '{data: frame_bad & ~|word ? WORD_RESET : word,
          framing: frame_bad, parity: par_bad, noise: s_reg.frame_noise};
        s_next.st.data_available_flag = 1'b1;
        if (s_next.fill == 2'd1) begin
          s_next.st.framing_flag = frame_bad;
          s_next.st.parity_error_flag = par_bad;
        end
        s_next.st.noise_flag = s_next.st.noise_flag | s_reg.frame_noise;
        s_next.rx_irq = ctrl.receive_interrupt_enable;
      end
    end

    // Break request qualification and break frames
    if (ctrl.break_request_bit) begin
      if (s_reg.req_cnt <= {1'b0, baud_divisor_value}) begin
        s_next.req_cnt = s_reg.req_cnt + 9'h001;
      end else begin
        s_next.brk_armed = 1'b1;
      end
    end else begin
      s_next.req_cnt = 9'h000;
      s_next.brk_armed = 1'b0;
    end
    if (tick) begin
      s_next.tx_ovs = s_reg.tx_ovs + 4'h1;
    end
    case (s_reg.tx_state)
      TX_IDLE: begin
        s_next.tx_pin = 1'b1;
        if (s_reg.brk_armed && tick && s_reg.tx_ovs == OVS_LAST) begin
          s_next.tx_state = TX_START;
          s_next.tx_pin = 1'b0;
        end
      end
      TX_START: begin
        if (tick && s_reg.tx_ovs == OVS_LAST) begin
          s_next.tx_state = TX_ZERO;
          s_next.tx_bits = COUNT_RESET;
        end
      end
      TX_ZERO: begin
        if (tick && s_reg.tx_ovs == OVS_LAST) begin
          s_next.tx_bits = s_reg.tx_bits + 5'h01;
          if (s_reg.tx_bits == {1'b0, BREAK_ZEROS} - 5'h01) begin
            if (ctrl.break_request_bit) begin
              s_next.tx_bits = COUNT_RESET;
            end else begin
              s_next.tx_state = TX_STOP;
              s_next.tx_pin = 1'b1;
              s_next.second_stop = ctrl.two_stop_bits;
            end
          end
        end
      end
      TX_STOP: begin
        if (tick && s_reg.tx_ovs == OVS_LAST) begin
          s_next.second_stop = 1'b0;
          if (!s_reg.second_stop) begin
            s_next.tx_state = TX_IDLE;
          end
        end
      end
      default: begin
        s_next.tx_state = TX_IDLE;
      end
    endcase

    // Port disable resets receiver, buffer and flags
    if (!ctrl.port_enable_bit || !ctrl.receive_enable_bit) begin
      s_next.rx_state = RX_OFF;
      s_next.rx_en = 1'b0;
      s_next.st.receive_idle_flag = 1'b1;
    end
    if (!ctrl.port_enable_bit) begin
      s_next.fill = 2'd0;
      s_next.st = '{data_available_flag: 1'b0, overrun_flag: 1'b0, noise_flag: 1'b0,
        framing_flag: 1'b0, parity_error_flag: 1'b0, receive_idle_flag: 1'b1};
      s_next.status_seen = 1'b0;
      s_next.rx_irq = 1'b0;
      s_next.tx_state = TX_IDLE;
      s_next.tx_pin = 1'b1;
      s_next.brk_armed = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      s_reg <= '0;
      s_reg.rx_state <= RX_OFF;
      s_reg.tx_state <= TX_IDLE;
      s_reg.tx_pin <= 1'b1;
      s_reg.st.receive_idle_flag <= 1'b1;
      s_reg.fifo <= {ENTRY_RESET, ENTRY_RESET};
    end else if (clk_en) begin
      s_reg <= s_next;
    end
  end

  assign status = s_reg.st;
  assign serial_data_buffer = s_reg.fifo[0].data[7:0];
  assign receive_ninth_bit = s_reg.fifo[0].data[8];
  assign receive_enable_out = s_reg.rx_en;
  assign rx_irq = s_reg.rx_irq;
  assign tx_pin = s_reg.tx_pin;
  assign tx_irq = 1'b0;
  assign break_active = (s_reg.tx_state != TX_IDLE);
endmodule : uart_receiver_and_break

// ==== verification/uart_rx_brk_monitor.sv ====
// Port checks for the receiver and break generator
`timescale 1ns/1ps
module uart_rx_brk_monitor (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire uart_rx_brk_pkg::ctrl_t ctrl,
  input wire logic [7:0] baud_divisor_value,
  input wire logic data_read,
  input wire uart_rx_brk_pkg::status_t status,
  input wire logic receive_enable_out,
  input wire logic rx_irq,
  input wire logic tx_pin,
  input wire logic tx_irq
);
  import uart_rx_brk_pkg::*;
  logic [15:0] low_reg;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // Length of the current low run on the break line
  always_ff @(posedge ref_clk) begin
    low_reg <= (!rst_b || tx_pin) ? 16'h0000 : low_reg + 16'h0001;
  end
  chk_no_tx_irq: assert property (!tx_irq)
    else $error("transmit interrupt raised");
  chk_break_armed: assert property ($fell(tx_pin) |-> $past(ctrl.break_request_bit))
    else $error("break without request");
  chk_break_len: assert property ($rose(tx_pin) |->
    low_reg % (16'd208 * (baud_divisor_value + 8'd1)) == 16'd16 * (baud_divisor_value + 8'd1)
    && low_reg > 16'd208 * (baud_divisor_value + 8'd1))
    else $error("break low run not start plus 13N bits");
  chk_irq_pulse: assert property (rx_irq |-> $past(ctrl.receive_interrupt_enable) ##1 !rx_irq)
    else $error("receive interrupt wrong");
  chk_noise_data: assert property ($rose(status.noise_flag) |-> status.data_available_flag)
    else $error("noise without data");
  chk_flag_clear: assert property (($fell(status.data_available_flag) ||
    $fell(status.overrun_flag)) |-> $past(data_read) || $past(!ctrl.port_enable_bit))
    else $error("flag cleared without read");
  chk_parity_gate: assert property ($rose(status.parity_error_flag) |->
    $past(ctrl.parity_enable_bit)) else $error("parity error while disabled");
  chk_port_off: assert property (!ctrl.port_enable_bit |=> !status.data_available_flag
    && !status.overrun_flag && status.receive_idle_flag && !receive_enable_out)
    else $error("disable left state");
  chk_store_idle: assert property ($rose(status.data_available_flag) |->
    status.receive_idle_flag) else $error("word stored while busy");
endmodule : uart_rx_brk_monitor
bind uart_receiver_and_break uart_rx_brk_monitor mon (.ref_clk(ref_clk), .rst_b(rst_b),
  .ctrl(ctrl), .baud_divisor_value(baud_divisor_value), .data_read(data_read),
  .status(status), .receive_enable_out(receive_enable_out), .rx_irq(rx_irq),
  .tx_pin(tx_pin), .tx_irq(tx_irq));

// ==== verification/uart_far_tx.sv ====
// Remote serial transmitter driving the receive line
`timescale 1ns/1ps
module uart_far_tx #(
  parameter int BIT_CLKS = 32
) (
  input wire logic ref_clk,
  output logic line
);
  initial line = 1'b1;
  task automatic put(input logic v, input int n);
    repeat (n) begin
      line = v;
      repeat (BIT_CLKS) @(posedge ref_clk);
      #2;
    end
  endtask : put
  // Start, data LSB first, optional parity, optional held-low tail, then two stop bits
  task automatic send(input logic [8:0] w, input int nb, input logic pe, input logic odd,
                      input logic bad, input int tail);
    logic p;
    p = (nb == 9 ? ^w : ^w[7:0]) ^ odd ^ bad;
    put(1'b0, 1);
    for (int i = 0; i < nb; i++) put(w[i], 1);
    if (pe) put(p, 1);
    if (tail > 0) put(1'b0, tail);
    put(1'b1, 2);
  endtask : send
endmodule : uart_far_tx

// ==== verification/tb_uart_receiver_and_break.sv ====
// Self-checking bench for the receiver and break generator
`timescale 1ns/1ps
module tb_uart_receiver_and_break;
  import uart_rx_brk_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  ctrl_t ctrl = '0;
  logic rx_pin;
  logic status_access = 1'b0;
  logic data_read = 1'b0;
  status_t status;
  logic [7:0] serial_data_buffer;
  logic receive_ninth_bit, receive_enable_out, rx_irq, tx_pin, tx_irq;
  int mismatches = 0;
  int total_checks = 0;
  int low_len;
  logic [10:0] exp_q[$];
  logic [10:0] w;
  logic [10:0] seen;
  assign seen = {status.framing_flag, status.parity_error_flag, receive_ninth_bit,
                 serial_data_buffer};
  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end
  uart_receiver_and_break dut (.ref_clk(ref_clk), .rst_b(rst_b), .clk_en(1'b1), .ctrl(ctrl),
    .baud_divisor_value(8'h01), .rx_pin(rx_pin), .status_access(status_access),
    .data_read(data_read), .status(status), .serial_data_buffer(serial_data_buffer),
    .receive_ninth_bit(receive_ninth_bit), .receive_enable_out(receive_enable_out),
    .rx_irq(rx_irq), .tx_pin(tx_pin), .tx_irq(tx_irq), .break_active());
  uart_far_tx #(.BIT_CLKS(32)) far (.ref_clk(ref_clk), .line(rx_pin));
  task automatic check(input string name, input logic [10:0] got, input logic [10:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask : check
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : finish_test
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask : step
  task automatic read_word;
    status_access = 1'b1;
    step(1);
    status_access = 1'b0;
    data_read = 1'b1;
    step(1);
    data_read = 1'b0;
    step(1);
  endtask : read_word
  task automatic rx(input logic [8:0] d, input int nb, input logic pe, input logic odd,
                    input logic bad);
    exp_q.push_back({1'b0, pe & bad, d});
    far.send(d, nb, pe, odd, bad, 0);
  endtask : rx
  // Head of buffer compared as each word is read out
  always @(posedge ref_clk) begin
    if (rst_b && data_read && exp_q.size() > 0) begin
      check("word", seen, exp_q.pop_front());
    end
  end
  initial begin
    #1_000_000;
    mismatches++;
    finish_test();
  end
  initial begin
    void'($urandom(17226));
    ctrl.port_enable_bit = 1'b1;
    ctrl.receive_enable_bit = 1'b1;
    ctrl.receive_interrupt_enable = 1'b1;
    step(20);
    rst_b = 1'b1;
    check("idle", 11'(status.receive_idle_flag), 11'h001);
    check("tx line", 11'(tx_pin), 11'h001);
    for (int m = 0; m < 6; m++) begin
      ctrl.word_length_select = m[0];
      ctrl.parity_enable_bit = m > 1;
      ctrl.parity_type_bit = ^m[2:0];
      w = 11'($urandom());
      rx(w[8:0] & {m[0], 8'hff}, m[0] ? 9 : 8, m > 1, ^m[2:0], m > 3);
      read_word();
    end
    $display("format test done");
    ctrl.word_length_select = 1'b0;
    ctrl.parity_enable_bit = 1'b0;
    rx(9'h0a5, 8, 1'b0, 1'b0, 1'b0);
    rx(9'h05a, 8, 1'b0, 1'b0, 1'b0);
    far.send(9'h0ff, 8, 1'b0, 1'b0, 1'b0, 0);
    check("overrun", 11'(status.overrun_flag), 11'h001);
    read_word();
    read_word();
    check("flags clear", 11'({status.overrun_flag, status.data_available_flag}), 11'h000);
    $display("overrun test done");
    exp_q.push_back(11'h400);
    far.send(9'h000, 8, 1'b0, 1'b0, 1'b0, 12);
    check("break idle", 11'(status.receive_idle_flag), 11'h001);
    read_word();
    w = 11'($urandom());
    rx({1'b0, w[7:0]}, 8, 1'b0, 1'b0, 1'b0);
    read_word();
    $display("break receive test done");
    low_len = 0;
    ctrl.break_request_bit = 1'b1;
    for (int i = 0; i < 3000; i++) begin
      if (i == 600) ctrl.break_request_bit = 1'b0;
      low_len += int'(!tx_pin);
      step(1);
    end
    check("break length", 11'((low_len - 32) % 416), 11'h000);
    check("break min", 11'(low_len >= 448), 11'h001);
    $display("break send test done");
    rx(9'h03c, 8, 1'b0, 1'b0, 1'b0);
    void'(exp_q.pop_back());
    ctrl.port_enable_bit = 1'b0;
    step(2);
    check("disable", 11'({status.data_available_flag, status.receive_idle_flag,
      receive_enable_out}), 11'h002);
    $display("disable test done");
    finish_test();
  end
endmodule : tb_uart_receiver_and_break
